// File: ddbc_top.sv
// Dual converter double-buffer control: serial receiver, registers, power modes
//
// Overview of operation
// - After sixteen bits, serial clock and data buffers turn off until frame falls.
// - A completed word loads the input register of the addressed channel.
// - Load strobe high: converter registers hold; input registers may change.
// - Load strobe low: converter register follows its input register.
// - Host writes both inputs then pulses load once; both update together.
// - A channel updates only if its input was written since last update.
// - Mode bits 13 and 12 set the mode of the addressed channel only.
// - Modes: 00 normal, 01 1k to ground, 10 100k, 11 high impedance.
// - Power-down disconnects output, adds termination, stops bias and amplifier.
// - Power-down leaves input and converter register contents unchanged.
// - Wake from power-down takes 2.5 us at 5 V, 5 us at 3 V.
// - Each data bit is sampled on the falling serial clock edge.
// - Bit 15 channel, bit 14 buffered reference, bits 13-12 mode, then code MSB first.
// - Exactly sixteen bits per frame; extra clocks ignored until frame re-falls.
// - Frame rising before sixteenth falling edge aborts; inputs unchanged.
// - Reset clears registers, normal mode, unbuffered reference.
`timescale 1ns/100ps
module ddbc_top
  import ddbc_pkg::*;
#(
  parameter int unsigned CODE_W = ddbc_pkg::DATA_W
) (
  // Clock, reset and clock enable
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              CE_I,
  // Serial link pins
  input  wire logic              SCLK_I,
  input  wire logic              SDIN_I,
  input  wire logic              FRAME_N_I,
  input  wire logic              LOAD_STROBE_N_I,
  // Supply selection for wake timing: 1 means low supply
  input  wire logic              LOW_SUPPLY_I,
  // Channel A state
  output logic [CODE_W-1:0]      CODE_A_O,
  output logic                   BUF_A_O,
  output ddbc_pkg::ddbc_mode_t   MODE_A_O,
  output logic                   AMP_ON_A_O,
  output logic                   OUT_READY_A_O,
  output logic [CODE_W-1:0]      INPUT_A_O,
  // Channel B state
  output logic [CODE_W-1:0]      CODE_B_O,
  output logic                   BUF_B_O,
  output ddbc_pkg::ddbc_mode_t   MODE_B_O,
  output logic                   AMP_ON_B_O,
  output logic                   OUT_READY_B_O,
  output logic [CODE_W-1:0]      INPUT_B_O,
  // Serial input buffer enable
  output logic                   LINK_BUF_EN_O
);
  import ddbc_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] sclk_s_q;
  logic [1:0] sdin_s_q;
  logic [1:0] frame_s_q;
  logic [1:0] load_s_q;
  logic [1:0] low_s_q;
  logic       sclk_prev_q;
  logic       frame_prev_q;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sclk_s_q  <= 2'h0;
      sdin_s_q  <= 2'h0;
      frame_s_q <= 2'h3;
      load_s_q  <= 2'h3;
      low_s_q   <= 2'h0;
    end else if (CE_I) begin
      sclk_s_q  <= {sclk_s_q[0], SCLK_I};
      sdin_s_q  <= {sdin_s_q[0], SDIN_I};
      frame_s_q <= {frame_s_q[0], FRAME_N_I};
      load_s_q  <= {load_s_q[0], LOAD_STROBE_N_I};
      low_s_q   <= {low_s_q[0], LOW_SUPPLY_I};
    end
  end

  logic sclk_s;
  logic sdin_s;
  logic frame_n_s;
  logic load_n_s;
  assign sclk_s    = sclk_s_q[1];
  assign sdin_s    = sdin_s_q[1];
  assign frame_n_s = frame_s_q[1];
  assign load_n_s  = load_s_q[1];

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sclk_prev_q  <= 1'b0;
      frame_prev_q <= 1'b1;
    end else if (CE_I) begin
      sclk_prev_q  <= sclk_s;
      frame_prev_q <= frame_n_s;
    end
  end

  logic sclk_fall;
  logic frame_fall;
  assign sclk_fall  = sclk_prev_q && !sclk_s;
  assign frame_fall = frame_prev_q && !frame_n_s;

  // ==========================================================================
  // Serial receiver
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_SHIFT = 3'b010,
    RX_DONE = 3'b100
  } ddbc_rx_t;

  ddbc_rx_t              rx_q;
  logic [WORD_BITS-1:0]  shift_q;
  logic [CNT_W-1:0]      bits_q;
  logic                  word_valid_q;
  logic                  fifo_in_ready;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rx_q         <= RX_IDLE;
      shift_q      <= '0;
      bits_q       <= '0;
      word_valid_q <= 1'b0;
    end else if (CE_I) begin
      if (word_valid_q && fifo_in_ready) begin
        word_valid_q <= 1'b0;
      end
      case (rx_q)
        RX_IDLE: begin
          if (frame_fall) begin
            rx_q   <= RX_SHIFT;
            bits_q <= '0;
          end
        end
        RX_SHIFT: begin
          if (frame_n_s) begin
            rx_q <= RX_IDLE;
          end else if (sclk_fall) begin
            shift_q <= {shift_q[WORD_BITS-2:0], sdin_s};
            if (bits_q == CNT_W'(WORD_BITS - 1)) begin
              rx_q         <= RX_DONE;
              word_valid_q <= 1'b1;
            end
            bits_q <= CNT_W'(bits_q + 1'b1);
          end
        end
        RX_DONE: begin
          if (frame_fall) begin
            rx_q   <= RX_SHIFT;
            bits_q <= '0;
          end
        end
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      LINK_BUF_EN_O <= 1'b1;
    end else if (CE_I) begin
      if (rx_q == RX_SHIFT && sclk_fall && bits_q == CNT_W'(WORD_BITS - 1)) begin
        LINK_BUF_EN_O <= 1'b0;
      end else if (frame_fall) begin
        LINK_BUF_EN_O <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Word FIFO
  logic                 fifo_out_valid;
  logic [WORD_BITS-1:0] fifo_out_data;

  ddbc_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rst_n_i     (RST_N_I),
    .ce_i        (CE_I),
    .in_valid_i  (word_valid_q),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (shift_q),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (1'b1),
    .out_data_o  (fifo_out_data)
  );

  // ==========================================================================
  // Input registers, mode and reference bits per channel
  logic [1:0]        wr_en;
  logic [CODE_W-1:0] in_code_q [2];
  logic [1:0]        buf_q;
  ddbc_mode_t        mode_q [2];
  logic [1:0]        written_q;
  logic [1:0]        load_en;
  logic [CODE_W-1:0] dac_q [2];
  logic [CODE_W-1:0] word_code;

  assign word_code = fifo_out_data[POS_DATA_MSB -: CODE_W];
  assign wr_en[0]  = fifo_out_valid && !fifo_out_data[POS_CHAN];
  assign wr_en[1]  = fifo_out_valid &&  fifo_out_data[POS_CHAN];

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      for (int c = 0; c < 2; c++) begin
        in_code_q[c] <= RST_CODE;
        mode_q[c]    <= DDBC_MODE_NORMAL;
      end
      buf_q <= {2{RST_BUF}};
    end else if (CE_I) begin
      for (int c = 0; c < 2; c++) begin
        if (wr_en[c]) begin
          in_code_q[c] <= word_code;
          buf_q[c]     <= fifo_out_data[POS_BUF];
          mode_q[c]    <= ddbc_mode_t'(fifo_out_data[POS_MODE_HI:POS_MODE_LO]);
        end
      end
    end
  end

  // ==========================================================================
  // Converter registers and written-since-update flags
  assign load_en = written_q & {2{!load_n_s}};

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      written_q <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        dac_q[c] <= RST_CODE;
      end
    end else if (CE_I) begin
      for (int c = 0; c < 2; c++) begin
        if (load_en[c]) begin
          dac_q[c] <= in_code_q[c];
        end
        // A write arriving with a load wins, so it is not lost
        if (wr_en[c]) begin
          written_q[c] <= 1'b1;
        end else if (load_en[c]) begin
          written_q[c] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Power control and wake timing
  logic [WAKE_W-1:0] wake_q [2];
  logic [WAKE_W-1:0] wake_len;
  assign wake_len = low_s_q[1] ? WAKE_W'(WAKE_3V_CYC) : WAKE_W'(WAKE_5V_CYC);

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      for (int c = 0; c < 2; c++) begin
        wake_q[c] <= '0;
      end
    end else if (CE_I) begin
      for (int c = 0; c < 2; c++) begin
        if (mode_q[c] != DDBC_MODE_NORMAL) begin
          wake_q[c] <= wake_len;
        end else if (wake_q[c] != '0) begin
          wake_q[c] <= WAKE_W'(wake_q[c] - 1'b1);
        end
      end
    end
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      CODE_A_O      <= RST_CODE;
      CODE_B_O      <= RST_CODE;
      INPUT_A_O     <= RST_CODE;
      INPUT_B_O     <= RST_CODE;
      BUF_A_O       <= RST_BUF;
      BUF_B_O       <= RST_BUF;
      MODE_A_O      <= DDBC_MODE_NORMAL;
      MODE_B_O      <= DDBC_MODE_NORMAL;
      AMP_ON_A_O    <= 1'b1;
      AMP_ON_B_O    <= 1'b1;
      OUT_READY_A_O <= 1'b1;
      OUT_READY_B_O <= 1'b1;
    end else if (CE_I) begin
      CODE_A_O      <= dac_q[0];
      CODE_B_O      <= dac_q[1];
      INPUT_A_O     <= in_code_q[0];
      INPUT_B_O     <= in_code_q[1];
      BUF_A_O       <= buf_q[0];
      BUF_B_O       <= buf_q[1];
      MODE_A_O      <= mode_q[0];
      MODE_B_O      <= mode_q[1];
      AMP_ON_A_O    <= (mode_q[0] == DDBC_MODE_NORMAL);
      AMP_ON_B_O    <= (mode_q[1] == DDBC_MODE_NORMAL);
      OUT_READY_A_O <= (mode_q[0] == DDBC_MODE_NORMAL) && (wake_q[0] == '0);
      OUT_READY_B_O <= (mode_q[1] == DDBC_MODE_NORMAL) && (wake_q[1] == '0);
    end
  end

  // ==========================================================================
  // Checks
  sequence s_last_bit;
    CE_I && rx_q == RX_SHIFT && !frame_n_s && sclk_fall && bits_q == CNT_W'(WORD_BITS - 1);
  endsequence
  sequence s_word_out;
    ##[1:4] wr_en != 2'h0;
  endsequence

  chk_buf_off_done: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_last_bit |=> !LINK_BUF_EN_O)
    else $error("link buffers stay on after last bit");
  chk_buf_on_frame: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && frame_fall |=> LINK_BUF_EN_O)
    else $error("link buffers not enabled by frame start");
  chk_ignore_extra: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    rx_q == RX_DONE |=> $stable(shift_q))
    else $error("bits shifted after sixteenth edge");
  chk_word_to_input: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_last_bit |-> s_word_out)
    else $error("completed word not written");
  chk_hold_on_high: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && load_n_s |=> $stable(dac_q[0]) && $stable(dac_q[1]))
    else $error("converter register changed with strobe high");
  chk_load_follow: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && load_en[0] |=> dac_q[0] == $past(in_code_q[0]))
    else $error("converter register did not take input");
  chk_no_stale_load: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && !written_q[1] |=> $stable(dac_q[1]))
    else $error("converter updated without new input");
  chk_abort_frame: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && rx_q == RX_SHIFT && frame_n_s |=> rx_q == RX_IDLE && !word_valid_q)
    else $error("aborted frame produced a word");
  chk_flag_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && load_en[0] && !wr_en[0] |=> !written_q[0])
    else $error("written flag not cleared on load");
  chk_amp_off: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CE_I && mode_q[1] != DDBC_MODE_NORMAL |=> !AMP_ON_B_O && !OUT_READY_B_O)
    else $error("amplifier on in power-down");
endmodule : ddbc_top

// File: ddbc_pkg.sv
// Package of constants and types for the dual converter control block
package ddbc_pkg;
  // ==========================================================================
  // Command word layout
  localparam int unsigned WORD_BITS    = 16;
  localparam int unsigned CNT_W        = 5;
  localparam int unsigned POS_CHAN     = 15;
  localparam int unsigned POS_BUF      = 14;
  localparam int unsigned POS_MODE_HI  = 13;
  localparam int unsigned POS_MODE_LO  = 12;
  localparam int unsigned POS_DATA_MSB = 11;
  localparam int unsigned DATA_W       = 12;
  // ==========================================================================
  // Power modes
  typedef enum logic [1:0] {
    DDBC_MODE_NORMAL = 2'h0,
    DDBC_MODE_PD_1K  = 2'h1,
    DDBC_MODE_PD_100K = 2'h2,
    DDBC_MODE_PD_HIZ = 2'h3
  } ddbc_mode_t;
  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] RST_CODE = 12'h000;
  localparam logic              RST_BUF  = 1'b0;
  // ==========================================================================
  // Power-up recovery times in ns and clock period
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned WAKE_5V_NS     = 2500;
  localparam int unsigned WAKE_3V_NS     = 5000;
  localparam int unsigned WAKE_5V_CYC    = (WAKE_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_3V_CYC    = (WAKE_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_W         = 8;
  localparam int unsigned FIFO_DEPTH     = 4;
endpackage : ddbc_pkg

// File: ddbc_fifo.sv
// Small word FIFO between the serial receiver and the input registers
`timescale 1ns/100ps
module ddbc_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  // Write side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Read side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_q <= ptr_inc(wr_q);
      end
      if (pop) begin
        rd_q <= ptr_inc(rd_q);
      end
      cnt_q <= AW'(0) + cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ddbc_fifo

// File: ddbc_host.sv
// Serial host model that drives the converter's three-wire link
`timescale 1ns/100ps
module ddbc_host (
  // Clock
  input  wire logic clk_i,
  // Serial link
  output logic      sclk_o,
  output logic      sdin_o,
  output logic      frame_n_o
);
  // ==========================================================================
  // Idle state: clock low and still, frame high
  initial begin
    sclk_o    = 1'b0;
    sdin_o    = 1'b0;
    frame_n_o = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_clk

  // ==========================================================================
  // One frame of nbits clocks; split pauses between two bytes
  task automatic send_word(input logic [15:0] word, input int nbits, input bit split);
    logic b;
    b = 1'b0;
    frame_n_o <= 1'b0;
    wait_clk(4);
    for (int i = 0; i < nbits; i++) begin
      b = (i < 16) ? word[15 - i] : ~word[i % 16];
      sclk_o <= 1'b1;
      sdin_o <= b;
      wait_clk(4);
      sclk_o <= 1'b0;
      wait_clk(4);
      if (split && i == 7) begin
        sdin_o <= ~b;
        wait_clk(12);
      end
    end
    frame_n_o <= 1'b1;
    sdin_o    <= ~b;
    wait_clk(6);
  endtask : send_word
endmodule : ddbc_host

// File: ddbc_top_tb.sv
// Self-checking testbench for the dual converter control block
`timescale 1ns/100ps
module ddbc_top_tb;
  import ddbc_pkg::*;
  // ==========================================================================
  // Signals
  logic             clk, rst_n, ce, load_n, low_supply, sclk, sdin, frame_n, link_en;
  logic [11:0]      code_a, code_b, inp_a, inp_b;
  logic             buf_a, buf_b, amp_a, amp_b, rdy_a, rdy_b;
  ddbc_mode_t       mode_a, mode_b;
  int               failures, num_checks, n;

  ddbc_host u_host (.clk_i(clk), .sclk_o(sclk), .sdin_o(sdin), .frame_n_o(frame_n));

  ddbc_top u_dut (
    .CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .SCLK_I(sclk), .SDIN_I(sdin), .FRAME_N_I(frame_n),
    .LOAD_STROBE_N_I(load_n), .LOW_SUPPLY_I(low_supply),
    .CODE_A_O(code_a), .BUF_A_O(buf_a), .MODE_A_O(mode_a), .AMP_ON_A_O(amp_a),
    .OUT_READY_A_O(rdy_a), .INPUT_A_O(inp_a),
    .CODE_B_O(code_b), .BUF_B_O(buf_b), .MODE_B_O(mode_b), .AMP_ON_B_O(amp_b),
    .OUT_READY_B_O(rdy_b), .INPUT_B_O(inp_b),
    .LINK_BUF_EN_O(link_en)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================================
  // Compare and closing tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_chan(input logic chb, input logic [11:0] e_inp, input logic [11:0] e_code);
    check(16'(chb ? inp_b : inp_a), 16'(e_inp));
    check(16'(chb ? code_b : code_a), 16'(e_code));
  endtask : check_chan

  task automatic complete_run;
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Access tasks
  task automatic write(input logic ch, input logic bf, input logic [1:0] md,
                       input logic [11:0] code, input bit split);
    u_host.send_word({ch, bf, md, code}, 16, split);
    repeat (12) @(posedge clk);
  endtask : write

  task automatic load_pulse;
    load_n <= 1'b0;
    repeat (4) @(posedge clk);
    load_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : load_pulse

  // About twelve frames of some 150 cycles plus two wake waits
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    failures   = 0;
    num_checks = 0;
    rst_n      = 1'b0;
    load_n     = 1'b1;
    ce         = 1'b1;
    low_supply = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check_chan(1'b0, 12'h000, 12'h000);
    check_chan(1'b1, 12'h000, 12'h000);
    check(16'({buf_a, buf_b, mode_a, mode_b}), 16'h0000);
    check(16'({amp_a, amp_b, rdy_a, rdy_b, link_en}), 16'h001f);
    // Write to A with strobe high: input changes, converter holds
    write(1'b0, 1'b1, DDBC_MODE_NORMAL, 12'ha5c, 1'b0);
    check_chan(1'b0, 12'ha5c, 12'h000);
    check_chan(1'b1, 12'h000, 12'h000);
    check(16'(buf_a), 16'h0001);
    check(16'(link_en), 16'h0000);
    // Two bytes to B; link buffers return after the frame falls
    fork
      write(1'b1, 1'b0, DDBC_MODE_NORMAL, 12'h3c1, 1'b1);
      begin
        wait (frame_n === 1'b0);
        repeat (8) @(posedge clk);
        check(16'(link_en), 16'h0001);
      end
    join
    check_chan(1'b1, 12'h3c1, 12'h000);
    load_pulse();
    check_chan(1'b0, 12'ha5c, 12'ha5c);
    check_chan(1'b1, 12'h3c1, 12'h3c1);
    // Aborted frame and overlong frame
    u_host.send_word(16'h0fff, 10, 1'b0);
    repeat (12) @(posedge clk);
    check_chan(1'b0, 12'ha5c, 12'ha5c);
    u_host.send_word(16'h0123, 20, 1'b0);
    repeat (12) @(posedge clk);
    check_chan(1'b0, 12'h123, 12'ha5c);
    // Clock enable low freezes all state, so a strobe then is not seen
    ce <= 1'b0;
    load_pulse();
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    check_chan(1'b0, 12'h123, 12'ha5c);
    // Strobe held low: converter follows each write
    load_n <= 1'b0;
    write(1'b0, 1'b0, DDBC_MODE_NORMAL, 12'h456, 1'b0);
    check_chan(1'b0, 12'h456, 12'h456);
    load_n <= 1'b1;
    // Every power-down mode on B only
    for (int m = 1; m < 4; m++) begin
      write(1'b1, 1'b0, 2'(m), 12'h3c1, 1'b0);
      check({6'h00, mode_a, 6'h00, mode_b}, 16'(m));
      check(16'({amp_a, amp_b, rdy_a, rdy_b}), 16'h000a);
      check_chan(1'b1, 12'h3c1, 12'h3c1);
    end
    // Wake timing at both supplies
    for (int s = 0; s < 2; s++) begin
      write(1'b1, 1'b0, DDBC_MODE_PD_HIZ, 12'h3c1, 1'b0);
      low_supply <= s[0];
      fork
        write(1'b1, 1'b0, DDBC_MODE_NORMAL, 12'h3c1, 1'b0);
        begin
          wait (amp_b === 1'b1);
          n = 0;
          while (rdy_b !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
          end
        end
      join
      check(16'(n >= (s ? WAKE_3V_CYC : WAKE_5V_CYC) - 2
            && n <= (s ? WAKE_3V_CYC : WAKE_5V_CYC) + 2), 16'h0001);
      repeat (250) @(posedge clk);
    end
    check_chan(1'b1, 12'h3c1, 12'h3c1);
    complete_run();
  end
endmodule : ddbc_top_tb
